/* design/dpll_cfg_pkg.sv */
package dpll_cfg_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFF_PIN_SIX_MAP  = 8'hE6;
   localparam logic [7:0] OFF_DELAY_EDGE   = 8'hEC;
   localparam logic [7:0] OFF_LOCK_RANGE   = 8'hED;
   localparam logic [7:0] OFF_MON_HO_MASK  = 8'hF4;
   localparam logic [7:0] OFF_REF_FAIL_MSK = 8'hF5;
   localparam logic [7:0] OFF_MON_LIMIT    = 8'hF7;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_PIN_SIX_MAP  = 8'h72;
   localparam logic [7:0] RST_DELAY_EDGE   = 8'h00;
   localparam logic [7:0] RST_LOCK_RANGE   = 8'h07;
   localparam logic [7:0] RST_MON_HO_MASK  = 8'hF0;
   localparam logic [7:0] RST_REF_FAIL_MSK = 8'h00;
   localparam logic [7:0] RST_MON_LIMIT    = 8'h33;

   // ==========================================================
   // Field positions
   localparam int IDX_LSB      = 0;
   localparam int IDX_W        = 7;
   localparam int ROLE_BIT     = 7;
   localparam int DELAY_LSB    = 0;
   localparam int DELAY_W      = 5;
   localparam int SENS_LSB     = 6;
   localparam int RANGE_LSB    = 0;
   localparam int RANGE_W      = 3;
   localparam int HO_MASK_BIT  = 4;
   localparam int RF_MASK_BIT  = 0;
   localparam int TABLE_BITS   = 128;
   localparam int TS_W         = 16;
   localparam int OFF_W        = 12;
   localparam int PPM_W        = 9;

   // ==========================================================
   // Hold-in / pull-in range codes
   localparam logic [2:0] RANGE_UNLIMITED = 3'h7;

   // Input sensitivity modes
   typedef enum logic [1:0] {
      SENS_RISE = 2'h0,
      SENS_FALL = 2'h1,
      SENS_LOW  = 2'h2,
      SENS_HIGH = 2'h3
   } sens_t;

   // Pulse tracker states, Gray along idle -> pulse
   typedef enum logic [1:0] {
      TRK_IDLE  = 2'h0,
      TRK_PULSE = 2'h1
   } trk_state_t;

endpackage

/* design/ref_event_if.sv */
`timescale 1ns/10ps
// Carries sensitivity mode and timing points between the register bank and the reference sampler
interface ref_event_if;
   import dpll_cfg_pkg::*;
   sens_t             sens;
   logic              event_pulse;
   logic [TS_W-1:0]   event_time;
   modport bank    (output sens, input event_pulse, input event_time);
   modport sampler (input sens, output event_pulse, output event_time);
endinterface

/* design/ref_sampler.sv */
`timescale 1ns/10ps
module ref_sampler
   import dpll_cfg_pkg::*;
(
   input  wire logic  mclk_in,
   input  wire logic  rst_b_in,
   input  wire logic  ce_in,
   input  wire logic  ref_clk_in,
   ref_event_if.sampler ev
);

   typedef struct packed {
      trk_state_t      st;
      logic            ref_prev;
      logic [TS_W-1:0] now;
      logic [TS_W-1:0] start;
      logic            pulse;
      logic [TS_W-1:0] tpoint;
   } smp_t;

   smp_t smp_q;
   smp_t smp_d;
   logic active_lvl;
   logic act_prev;
   logic [TS_W-1:0] width;

   // ==========================================================
   // Timing point extraction
   // Pulse modes report the midpoint, so the event is late by half a pulse
   always_comb begin
      smp_d          = smp_q;
      smp_d.ref_prev = ref_clk_in;
      smp_d.now      = smp_q.now + 16'h0001;
      smp_d.pulse    = 1'b0;
      active_lvl     = (ev.sens == SENS_HIGH) ? ref_clk_in : ~ref_clk_in;
      act_prev       = (ev.sens == SENS_HIGH) ? smp_q.ref_prev : ~smp_q.ref_prev;
      width          = smp_q.now - smp_q.start;
      unique case (ev.sens)
         SENS_RISE: begin
            if (ref_clk_in && !smp_q.ref_prev) begin
               smp_d.pulse  = 1'b1;
               smp_d.tpoint = smp_q.now;
            end
            smp_d.st = TRK_IDLE;
         end
         SENS_FALL: begin
            if (!ref_clk_in && smp_q.ref_prev) begin
               smp_d.pulse  = 1'b1;
               smp_d.tpoint = smp_q.now;
            end
            smp_d.st = TRK_IDLE;
         end
         SENS_LOW, SENS_HIGH: begin
            unique case (smp_q.st)
               TRK_IDLE: begin
                  if (active_lvl && !act_prev) begin
                     smp_d.start = smp_q.now;
                     smp_d.st    = TRK_PULSE;
                  end
               end
               TRK_PULSE: begin
                  if (!active_lvl) begin
                     smp_d.pulse  = 1'b1;
                     smp_d.tpoint = smp_q.start + (width >> 1);
                     smp_d.st     = TRK_IDLE;
                  end
               end
               default: smp_d.st = TRK_IDLE;
            endcase
         end
      endcase
   end

   // Single state register, frozen while clock enable is low
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         smp_q <= '0;
      end else if (ce_in) begin
         smp_q <= smp_d;
      end
   end

   assign ev.event_pulse = smp_q.pulse;
   assign ev.event_time  = smp_q.tpoint;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);

   a_rise_event_seen: assert property (ce_in && ev.sens == SENS_RISE && ref_clk_in && !smp_q.ref_prev
      |=> ev.event_pulse && ev.event_time == $past(smp_q.now))
      else $error("rising edge produced no timing point");
   a_pulse_midpoint: assert property (ce_in && smp_q.st == TRK_PULSE && !active_lvl && ev.sens[1]
      |=> ev.event_pulse && ev.event_time == $past(smp_q.start) + ($past(width) >> 1))
      else $error("pulse timing point is not the midpoint");
   c_pulse_seen: cover property (ev.event_pulse && ev.sens == SENS_HIGH);

endmodule

/* design/dpll_ref_monitor_cfg.sv */
`timescale 1ns/10ps
module dpll_ref_monitor_cfg
   import dpll_cfg_pkg::*;
(
   input  wire logic                  mclk_in,
   input  wire logic                  rst_b_in,
   input  wire logic                  ce_in,
   input  wire logic [7:0]            reg_addr_in,
   input  wire logic                  reg_wr_en_in,
   input  wire logic                  reg_rd_en_in,
   input  wire logic [7:0]            reg_wdata_in,
   output logic      [7:0]            reg_rdata_out,
   input  wire logic                  pin_six_in,
   output logic                       pin_six_out,
   output logic                       pin_six_oe_b_out,
   input  wire logic [TABLE_BITS-1:0] status_table_in,
   output logic      [TABLE_BITS-1:0] control_table_out,
   input  wire logic                  ref_clk_in,
   output logic                       ref_event_out,
   output logic      [TS_W-1:0]       ref_event_time_out,
   input  wire logic                  offset_valid_in,
   input  wire logic [OFF_W-1:0]      offset_tenth_ppm_in,
   output logic                       ref_accepted_out,
   output logic                       ref_fail_alarm_out,
   output logic                       holdover_request_out,
   output logic      [DELAY_W-1:0]    holdover_delay_code_out,
   output logic      [PPM_W-1:0]      lock_range_ppm_out,
   output logic                       lock_range_unlimited_out
);

   // ==========================================================
   // Lookup functions
   // Limits are in tenths of a ppm so the half-ppm entries stay exact
   function automatic logic [OFF_W-1:0] accept_limit(input logic [2:0] code);
      unique case (code)
         3'h0: accept_limit = 12'h05C;
         3'h1: accept_limit = 12'h190;
         3'h2: accept_limit = 12'h280;
         3'h3: accept_limit = 12'h3E8;
         3'h4: accept_limit = 12'h08A;
         3'h5: accept_limit = 12'h0F6;
         3'h6: accept_limit = 12'h150;
         3'h7: accept_limit = 12'h208;
      endcase
   endfunction

   // Each rejection limit sits above its acceptance limit, leaving a hold band
   function automatic logic [OFF_W-1:0] reject_limit(input logic [2:0] code);
      unique case (code)
         3'h0: reject_limit = 12'h078;
         3'h1: reject_limit = 12'h208;
         3'h2: reject_limit = 12'h33E;
         3'h3: reject_limit = 12'h514;
         3'h4: reject_limit = 12'h0B4;
         3'h5: reject_limit = 12'h140;
         3'h6: reject_limit = 12'h1DB;
         3'h7: reject_limit = 12'h2A3;
      endcase
   endfunction

   // Reserved codes report zero ppm, limited; software must not use them
   function automatic logic [PPM_W-1:0] lock_ppm(input logic [2:0] code);
      unique case (code)
         3'h0: lock_ppm = 9'h00C;
         3'h1: lock_ppm = 9'h034;
         3'h2: lock_ppm = 9'h053;
         3'h3: lock_ppm = 9'h082;
         3'h4: lock_ppm = 9'h190;
         default: lock_ppm = 9'h000;
      endcase
   endfunction

   // ==========================================================
   // State
   typedef struct packed {
      logic [7:0]            pin_map;
      logic [7:0]            delay_edge;
      logic [7:0]            lock_range;
      logic [7:0]            ho_mask;
      logic [7:0]            rf_mask;
      logic [7:0]            mon_limit;
      logic [7:0]            rdata;
      logic [TABLE_BITS-1:0] ctrl;
      logic                  pin_o;
      logic                  accepted;
   } bank_t;

   bank_t bank_q;
   bank_t bank_d;

   logic [IDX_W-1:0]   pin_idx;
   logic               pin_role;
   logic               status_sel;
   logic [OFF_W-1:0]   acc_lim;
   logic [OFF_W-1:0]   rej_lim;
   logic [RANGE_W-1:0] mon_code;
   logic               alarm;

   // Sensitivity goes down to the sampler, timing points come back up
   ref_event_if ev_if ();

   // ==========================================================
   // Field views
   assign pin_idx    = bank_q.pin_map[IDX_LSB +: IDX_W];
   assign pin_role   = bank_q.pin_map[ROLE_BIT];
   assign status_sel = status_table_in[pin_idx];
   assign mon_code   = bank_q.mon_limit[RANGE_LSB +: RANGE_W];
   assign acc_lim    = accept_limit(mon_code);
   assign rej_lim    = reject_limit(mon_code);
   assign alarm      = ~bank_q.accepted;
   assign ev_if.sens = sens_t'(bank_q.delay_edge[SENS_LSB +: 2]);

   // ==========================================================
   // Next state: register writes, read data, pin, monitor
   always_comb begin
      bank_d = bank_q;
      // Register port; unmapped reads return zero, unmapped writes drop
      if (reg_wr_en_in) begin
         unique case (reg_addr_in)
            OFF_PIN_SIX_MAP:  bank_d.pin_map    = reg_wdata_in;
            OFF_DELAY_EDGE:   bank_d.delay_edge = reg_wdata_in;
            OFF_LOCK_RANGE:   bank_d.lock_range = reg_wdata_in;
            OFF_MON_HO_MASK:  bank_d.ho_mask    = reg_wdata_in;
            OFF_REF_FAIL_MSK: bank_d.rf_mask    = reg_wdata_in;
            OFF_MON_LIMIT:    bank_d.mon_limit  = reg_wdata_in;
            default: ;
         endcase
      end
      // Reads see the value from before a write in the same cycle
      if (reg_rd_en_in) begin
         unique case (reg_addr_in)
            OFF_PIN_SIX_MAP:  bank_d.rdata = bank_q.pin_map;
            OFF_DELAY_EDGE:   bank_d.rdata = bank_q.delay_edge;
            OFF_LOCK_RANGE:   bank_d.rdata = bank_q.lock_range;
            OFF_MON_HO_MASK:  bank_d.rdata = bank_q.ho_mask;
            OFF_REF_FAIL_MSK: bank_d.rdata = bank_q.rf_mask;
            OFF_MON_LIMIT:    bank_d.rdata = bank_q.mon_limit;
            default:          bank_d.rdata = 8'h00;
         endcase
      end
      // Pin as control input writes only the addressed table bit
      if (!pin_role) begin
         bank_d.ctrl[pin_idx] = pin_six_in;
      end
      // Pin as status output copies the addressed status bit
      bank_d.pin_o = pin_role ? status_sel : 1'b0;
      // Hysteresis: the band between the limits holds the last verdict
      if (offset_valid_in) begin
         if (offset_tenth_ppm_in <= acc_lim) begin
            bank_d.accepted = 1'b1;
         end else if (offset_tenth_ppm_in > rej_lim) begin
            bank_d.accepted = 1'b0;
         end
      end
   end

   // Single state register, frozen while clock enable is low
   // Verdict resets to accepted so no alarm or holdover request leaves reset
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bank_q            <= '0;
         bank_q.pin_map    <= RST_PIN_SIX_MAP;
         bank_q.delay_edge <= RST_DELAY_EDGE;
         bank_q.lock_range <= RST_LOCK_RANGE;
         bank_q.ho_mask    <= RST_MON_HO_MASK;
         bank_q.rf_mask    <= RST_REF_FAIL_MSK;
         bank_q.mon_limit  <= RST_MON_LIMIT;
         bank_q.accepted   <= 1'b1;
      end else if (ce_in) begin
         bank_q <= bank_d;
      end
   end

   // ==========================================================
   // Reference sampler
   ref_sampler u_sampler (
      .mclk_in    (mclk_in),
      .rst_b_in   (rst_b_in),
      .ce_in      (ce_in),
      .ref_clk_in (ref_clk_in),
      .ev         (ev_if.sampler)
   );

   // ==========================================================
   // Outputs
   assign reg_rdata_out            = bank_q.rdata;
   assign pin_six_out              = bank_q.pin_o;
   assign pin_six_oe_b_out         = ~pin_role;
   assign control_table_out        = bank_q.ctrl;
   assign ref_event_out            = ev_if.event_pulse;
   assign ref_event_time_out       = ev_if.event_time;
   assign ref_accepted_out         = bank_q.accepted;
   // Masks gate the alarm's effects, not the monitor verdict itself
   assign ref_fail_alarm_out       = alarm & bank_q.rf_mask[RF_MASK_BIT];
   assign holdover_request_out     = alarm & bank_q.ho_mask[HO_MASK_BIT];
   assign holdover_delay_code_out  = bank_q.delay_edge[DELAY_LSB +: DELAY_W];
   // Range is decoded from the register; reserved codes show zero ppm, limited
   assign lock_range_ppm_out       = lock_ppm(bank_q.lock_range[RANGE_LSB +: RANGE_W]);
   assign lock_range_unlimited_out = bank_q.lock_range[RANGE_LSB +: RANGE_W] == RANGE_UNLIMITED;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);

   a_ctrl_bit_capture: assert property (ce_in && !pin_role
      |=> control_table_out[$past(pin_idx)] == $past(pin_six_in))
      else $error("control table bit did not follow the pin");
   a_status_pin_drive: assert property (ce_in && pin_role && !reg_wr_en_in
      |=> pin_six_out == $past(status_sel) && !pin_six_oe_b_out)
      else $error("status pin does not show the selected bit");
   a_control_pin_quiet: assert property (!pin_role |-> pin_six_oe_b_out)
      else $error("pin driven while in control role");
   a_map_after_reset: assert property ($rose(rst_b_in) |-> bank_q.pin_map == RST_PIN_SIX_MAP)
      else $error("pin six mapping not at its reset value");
   a_accept_inside: assert property (ce_in && offset_valid_in && offset_tenth_ppm_in <= acc_lim
      |=> ref_accepted_out)
      else $error("offset inside acceptance range rejected");
   a_reject_outside: assert property (ce_in && offset_valid_in && offset_tenth_ppm_in > rej_lim
      |=> !ref_accepted_out)
      else $error("offset outside rejection range accepted");
   a_hold_between: assert property (ce_in && (!offset_valid_in || (offset_tenth_ppm_in > acc_lim
      && offset_tenth_ppm_in <= rej_lim)) |=> $stable(ref_accepted_out))
      else $error("verdict changed inside hysteresis band");
   a_limit_order: assert property (acc_lim < rej_lim)
      else $error("acceptance limit not below rejection limit");
   a_holdover_gate: assert property (!bank_q.ho_mask[HO_MASK_BIT] |-> !holdover_request_out)
      else $error("masked alarm still forces holdover");
   a_fail_alarm_gate: assert property (ref_fail_alarm_out |-> bank_q.rf_mask[RF_MASK_BIT]
      && !ref_accepted_out)
      else $error("reference fail alarm without unmasked rejection");
   a_unlimited_range: assert property (lock_range_unlimited_out |-> lock_range_ppm_out == 9'h000)
      else $error("unlimited range reports a ppm figure");
   a_delay_code_held: assert property (ce_in && !reg_wr_en_in |=> $stable(holdover_delay_code_out))
      else $error("storage delay code changed without a write");

   // ==========================================================
   // Register writes reach their views one cycle after the strobe
   a_index_follows_write: assert property (ce_in && reg_wr_en_in && reg_addr_in == OFF_PIN_SIX_MAP
      |=> pin_idx == $past(reg_wdata_in[IDX_LSB +: IDX_W]))
      else $error("table index missed its write");
   a_role_follows_write: assert property (ce_in && reg_wr_en_in && reg_addr_in == OFF_PIN_SIX_MAP
      |=> pin_six_oe_b_out == !$past(reg_wdata_in[ROLE_BIT]))
      else $error("pin role missed its write");
   a_delay_code_write: assert property (ce_in && reg_wr_en_in && reg_addr_in == OFF_DELAY_EDGE
      |=> holdover_delay_code_out == $past(reg_wdata_in[DELAY_LSB +: DELAY_W]))
      else $error("storage delay code missed its write");
   a_sens_follows_write: assert property (ce_in && reg_wr_en_in && reg_addr_in == OFF_DELAY_EDGE
      |=> ev_if.sens == $past(reg_wdata_in[SENS_LSB +: 2]))
      else $error("sensitivity missed its write");
   a_unlimited_write: assert property (ce_in && reg_wr_en_in && reg_addr_in == OFF_LOCK_RANGE
      |=> lock_range_unlimited_out == ($past(reg_wdata_in[RANGE_LSB +: RANGE_W]) == RANGE_UNLIMITED))
      else $error("unlimited flag missed its write");
   a_monitor_code_write: assert property (ce_in && reg_wr_en_in && reg_addr_in == OFF_MON_LIMIT
      |=> mon_code == $past(reg_wdata_in[RANGE_LSB +: RANGE_W]))
      else $error("monitor code missed its write");
   a_limit_readback: assert property (ce_in && reg_rd_en_in && reg_addr_in == OFF_MON_LIMIT
      |=> reg_rdata_out == $past(bank_q.mon_limit))
      else $error("monitor limit read back wrong");

   // ==========================================================
   // Pin six table: only the addressed control bit may move
   a_ctrl_others_hold: assert property (ce_in && !pin_role
      |=> (control_table_out | (TABLE_BITS'(1) << $past(pin_idx)))
          == ($past(control_table_out) | (TABLE_BITS'(1) << $past(pin_idx))))
      else $error("unaddressed control bit moved");
   a_ctrl_frozen_status: assert property (ce_in && pin_role |=> $stable(control_table_out))
      else $error("control table moved in status role");

   // ==========================================================
   // Reset values and alarm effects
   a_range_after_reset: assert property ($rose(rst_b_in) |-> lock_range_unlimited_out)
      else $error("lock range limited after reset");
   a_masks_after_reset: assert property ($rose(rst_b_in) |-> bank_q.ho_mask == RST_MON_HO_MASK
      && bank_q.rf_mask == RST_REF_FAIL_MSK)
      else $error("alarm masks not at reset values");
   // A mask written in the same cycle as the offset is left out
   a_holdover_raised: assert property (ce_in && offset_valid_in && offset_tenth_ppm_in > rej_lim
      && bank_q.ho_mask[HO_MASK_BIT] && !(reg_wr_en_in && reg_addr_in == OFF_MON_HO_MASK)
      |=> holdover_request_out)
      else $error("unmasked rejection requested no holdover");
   a_fail_alarm_raised: assert property (ce_in && offset_valid_in && offset_tenth_ppm_in > rej_lim
      && bank_q.rf_mask[RF_MASK_BIT] && !(reg_wr_en_in && reg_addr_in == OFF_REF_FAIL_MSK)
      |=> ref_fail_alarm_out)
      else $error("unmasked rejection raised no alarm");

   // Scenarios worth seeing at least once
   c_reject_then_accept: cover property (!ref_accepted_out ##[1:50] ref_accepted_out);
   c_status_role: cover property (pin_role && pin_six_out);
   c_holdover_req: cover property (holdover_request_out);
   c_low_pulse_event: cover property (ev_if.sens == SENS_LOW && ref_event_out);

endmodule

/* tb/ref_clk_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Reference source: pulses on command, stands still between them
module ref_clk_model (
   input  wire logic mclk_in,
   output logic      ref_out
);
   initial begin
      ref_out = 1'b0;
   end
   // Idle level; a low-pulse reference rests high
   task automatic set_idle(input logic lvl);
      @(posedge mclk_in);
      ref_out <= lvl;
   endtask
   // Start spacing of two calls is width plus gap
   task automatic pulse(input logic idle_lvl, input int width, input int gap);
      @(posedge mclk_in);
      ref_out <= ~idle_lvl;
      repeat (width) @(posedge mclk_in);
      ref_out <= idle_lvl;
      repeat (gap - 1) @(posedge mclk_in);
   endtask
endmodule

/* tb/dpll_reference_monitor_config_tb_top.sv */
`timescale 1ns/10ps
module dpll_reference_monitor_config_tb_top
   import dpll_cfg_pkg::*;
;
   logic                  mclk_in, rst_b_in, ce_in, reg_wr_en_in, reg_rd_en_in, pin_six_in, ref_clk_in;
   logic [7:0]            reg_addr_in, reg_wdata_in, reg_rdata_out, rd_v;
   logic                  pin_six_out, pin_six_oe_b_out, ref_event_out, offset_valid_in;
   logic [TABLE_BITS-1:0] status_table_in, control_table_out;
   logic [TS_W-1:0]       ref_event_time_out, evq [$];
   logic [OFF_W-1:0]      offset_tenth_ppm_in;
   logic                  ref_accepted_out, ref_fail_alarm_out, holdover_request_out, lock_range_unlimited_out;
   logic [DELAY_W-1:0]    holdover_delay_code_out;
   logic [PPM_W-1:0]      lock_range_ppm_out;
   int                    err_total, samples_checked;
   logic [7:0] offs [6] = '{OFF_PIN_SIX_MAP, OFF_DELAY_EDGE, OFF_LOCK_RANGE, OFF_MON_HO_MASK, OFF_REF_FAIL_MSK,
                            OFF_MON_LIMIT};
   logic [7:0] rsts [6] = '{8'h72, 8'h00, 8'h07, 8'hF0, 8'h00, 8'h33};
   int ppm [5] = '{12, 52, 83, 130, 400};
   int acc [8] = '{92, 400, 640, 1000, 138, 246, 336, 520};
   int rej [8] = '{120, 520, 830, 1300, 180, 320, 475, 675};
   int dif [4] = '{10, 14, 12, 12};

   dpll_ref_monitor_cfg dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
      .reg_wr_en_in(reg_wr_en_in), .reg_rd_en_in(reg_rd_en_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .pin_six_in(pin_six_in), .pin_six_out(pin_six_out),
      .pin_six_oe_b_out(pin_six_oe_b_out), .status_table_in(status_table_in),
      .control_table_out(control_table_out), .ref_clk_in(ref_clk_in), .ref_event_out(ref_event_out),
      .ref_event_time_out(ref_event_time_out), .offset_valid_in(offset_valid_in),
      .offset_tenth_ppm_in(offset_tenth_ppm_in), .ref_accepted_out(ref_accepted_out),
      .ref_fail_alarm_out(ref_fail_alarm_out), .holdover_request_out(holdover_request_out),
      .holdover_delay_code_out(holdover_delay_code_out), .lock_range_ppm_out(lock_range_ppm_out),
      .lock_range_unlimited_out(lock_range_unlimited_out));
   ref_clk_model src (.mclk_in(mclk_in), .ref_out(ref_clk_in));

   // ==========================================================
   // Clock and event collector
   always begin
      #2.5 mclk_in = ~mclk_in;
   end
   // Flag and time come from the same registered state, so sampling at the edge is safe
   always @(posedge mclk_in) begin
      if (ref_event_out === 1'b1) begin
         evq.push_back(ref_event_time_out);
      end
   end

   // ==========================================================
   // Checking and closing
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Run is a few hundred cycles; this is a generous margin
   initial begin
      repeat (20000) @(posedge mclk_in);
      err_total++;
      $display("unexpected at %0t: watchdog expired", $time);
      test_done();
   end

   // ==========================================================
   // Register port: one-cycle strobes, read data settles a cycle later
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_en_in <= 1'b1;
      @(posedge mclk_in);
      reg_wr_en_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_in);
      reg_addr_in  <= a;
      reg_rd_en_in <= 1'b1;
      @(posedge mclk_in);
      reg_rd_en_in <= 1'b0;
      #1;
      d = reg_rdata_out;
   endtask
   task automatic mon(input int tenths, input logic exp_acc);
      @(posedge mclk_in);
      offset_valid_in     <= 1'b1;
      offset_tenth_ppm_in <= OFF_W'(tenths);
      @(posedge mclk_in);
      offset_valid_in <= 1'b0;
      #1;
      chk(ref_accepted_out, exp_acc);
   endtask

   // ==========================================================
   // Tests
   initial begin
      mclk_in = 0; rst_b_in = 0; ce_in = 1; reg_addr_in = 8'h00; reg_wdata_in = 8'h00;
      reg_wr_en_in = 0; reg_rd_en_in = 0; pin_six_in = 0; status_table_in = '0;
      offset_valid_in = 0; offset_tenth_ppm_in = '0; err_total = 0; samples_checked = 0;
      repeat (15) @(posedge mclk_in);
      #1;
      chk(pin_six_oe_b_out, 1'b1);
      chk(lock_range_unlimited_out, 1'b1);
      @(posedge mclk_in);
      rst_b_in <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(offs[i], rd_v);
         chk(rd_v, rsts[i]);
      end
      wr(8'hE7, 8'h5A);
      rd(8'hE7, rd_v);
      chk(rd_v, 8'h00);
      $display("test reset_values done");

      // Delay code and frozen port while the clock enable is low
      wr(OFF_DELAY_EDGE, 8'h1D);
      rd(OFF_DELAY_EDGE, rd_v);
      chk(rd_v, 8'h1D);
      chk(holdover_delay_code_out, 5'h1D);
      @(posedge mclk_in);
      ce_in <= 1'b0;
      wr(OFF_DELAY_EDGE, 8'h08);
      @(posedge mclk_in);
      ce_in <= 1'b1;
      #1;
      chk(holdover_delay_code_out, 5'h1D);
      $display("test delay_code done");

      // Every legal range code; the two reserved ones are never written
      for (int c = 0; c < 8; c++) begin
         if (c == 5 || c == 6) continue;
         wr(OFF_LOCK_RANGE, 8'(c));
         #1;
         chk(lock_range_ppm_out, (c == 7) ? 9'h000 : PPM_W'(ppm[c % 5]));
         chk(lock_range_unlimited_out, c == 7);
      end
      $display("test lock_range done");

      // Pin six: control role at the reset index, then status role
      @(posedge mclk_in);
      pin_six_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      #1;
      chk(control_table_out, 128'h1 << 8'h72);
      chk(pin_six_out, 1'b0);
      wr(OFF_PIN_SIX_MAP, 8'h85);
      status_table_in <= 128'h20;
      pin_six_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      #1;
      chk(pin_six_oe_b_out, 1'b0);
      chk(pin_six_out, 1'b1);
      chk(control_table_out, 128'h1 << 8'h72);
      status_table_in <= 128'h10;
      repeat (2) @(posedge mclk_in);
      #1;
      chk(pin_six_out, 1'b0);
      $display("test pin_six done");

      // Hysteresis for every monitor code; reserved bits keep their reset value
      for (int c = 0; c < 8; c++) begin
         wr(OFF_MON_LIMIT, 8'h30 | 8'(c));
         mon(acc[c], 1'b1);
         mon(rej[c] + 1, 1'b0);
         mon(rej[c], 1'b0);
         mon(acc[c] + 1, 1'b0);
         mon(acc[c], 1'b1);
         mon(rej[c], 1'b1);
      end
      $display("test monitor_ranges done");

      // Alarm gating by the two mask registers
      mon(1301, 1'b0);
      chk(holdover_request_out, 1'b1);
      chk(ref_fail_alarm_out, 1'b0);
      wr(OFF_REF_FAIL_MSK, 8'h01);
      wr(OFF_MON_HO_MASK, 8'hE0);
      #1;
      chk(ref_fail_alarm_out, 1'b1);
      chk(holdover_request_out, 1'b0);
      mon(520, 1'b1);
      chk(ref_fail_alarm_out, 1'b0);
      $display("test alarm_masks done");

      // Two pulses of widths 2 and 6, starts 10 cycles apart, in each mode
      for (int m = 0; m < 4; m++) begin
         src.set_idle(m == 2);
         wr(OFF_DELAY_EDGE, 8'(m) << SENS_LSB);
         repeat (4) @(posedge mclk_in);
         #1;
         evq.delete();
         src.pulse(m == 2, 2, 8);
         src.pulse(m == 2, 6, 8);
         repeat (8) @(posedge mclk_in);
         #1;
         chk(evq.size(), 2);
         if (evq.size() == 2) begin
            chk(TS_W'(evq[1] - evq[0]), TS_W'(dif[m]));
         end
      end
      $display("test sampler_modes done");
      test_done();
   end
endmodule
